// >>> rtl/nco_dev.sv
/*
  NCO device end: latches host writes into frequency and phase offset
  registers and runs the phase accumulator feeding the sine table address.
  Assumes the host holds data and address steady for three aclk cycles
  after raising the write strobe, as all pins are synchronised here.
*/
`timescale 1ns/1ns
`include "nco_regs.svh"

module nco_dev
  import nco_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  nco_if.dev          link,
  output nco_phase_type sine_phase,
  output logic        dac_enable,
  output logic        ref_voltage_out
);

  localparam int SYNC_W = 1 + `NCO_ADDR_W + `NCO_HALF_W + 5;
  // Strobe, sleep and reset idle high so release makes no false edge
  localparam logic [SYNC_W-1:0] SYNC_RST =
    {1'b1, {(`NCO_ADDR_W + `NCO_HALF_W + 3){1'b0}}, 1'b1, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic          s_wr_n;
  nco_dest_type  s_addr;
  nco_half_type  s_data;
  logic          s_fsel;
  logic          s_pslo;
  logic          s_pshi;
  logic          s_sleep_n;
  logic          s_reset_n;

  nco_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({link.wr_n, link.host_addr_bus, link.host_data_bus,
               link.freq_word_sel, link.phase_sel_hi, link.phase_sel_lo,
               link.sleep_n, link.reset_n}),
    .dout    ({s_wr_n, s_addr, s_data, s_fsel, s_pshi, s_pslo,
               s_sleep_n, s_reset_n})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic freq_hit(nco_dest_type a, int word, int half);
    freq_hit = !a[`NCO_A_PHASE_BIT] &&
               (a[`NCO_A_WORD_BIT] == word[0]) &&
               (a[`NCO_A_HALF_BIT] == half[0]);
  endfunction : freq_hit

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic          wr_d_r;
  logic          wr_d_nxt;
  logic          pend_r;
  logic          pend_nxt;
  nco_half_type  hold_data_r;
  nco_half_type  hold_data_nxt;
  nco_dest_type  hold_addr_r;
  nco_dest_type  hold_addr_nxt;
  nco_word_type  freq_r    [`NCO_NUM_FREQ];
  nco_word_type  freq_nxt  [`NCO_NUM_FREQ];
  nco_phase_type pofs_r    [`NCO_NUM_POFS];
  nco_phase_type pofs_nxt  [`NCO_NUM_POFS];
  logic          fsel_r;
  logic          fsel_nxt;
  logic [1:0]    psel_r;
  logic [1:0]    psel_nxt;
  nco_word_type  acc_r;
  nco_word_type  acc_nxt;
  nco_phase_type phase_r;
  nco_phase_type phase_nxt;
  logic          awake_r;
  logic          awake_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Write path: capture on strobe, load one edge later

  always_comb begin
    wr_d_nxt      = s_wr_n;
    pend_nxt      = 1'b0;
    hold_data_nxt = hold_data_r;
    hold_addr_nxt = hold_addr_r;
    freq_nxt      = freq_r;
    pofs_nxt      = pofs_r;
    if (s_sleep_n) begin
      if (s_wr_n && !wr_d_r) begin
        hold_data_nxt = s_data;
        hold_addr_nxt = s_addr;
        pend_nxt      = 1'b1;
      end
      if (pend_r) begin
        for (int w = 0; w < `NCO_NUM_FREQ; w++) begin
          for (int h = 0; h < 2; h++) begin
            if (freq_hit(hold_addr_r, w, h)) begin
              freq_nxt[w][h*`NCO_HALF_W +: `NCO_HALF_W] = hold_data_r;
            end
          end
        end
        if (hold_addr_r[`NCO_A_PHASE_BIT]) begin
          pofs_nxt[hold_addr_r[1:0]] = hold_data_r[`NCO_PHASE_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_d_r      <= 1'b1;
      pend_r      <= 1'b0;
      hold_data_r <= '0;
      hold_addr_r <= '0;
      for (int i = 0; i < `NCO_NUM_FREQ; i++) begin
        freq_r[i] <= '0;
      end
      for (int i = 0; i < `NCO_NUM_POFS; i++) begin
        pofs_r[i] <= '0;
      end
    end else begin
      wr_d_r      <= wr_d_nxt;
      pend_r      <= pend_nxt;
      hold_data_r <= hold_data_nxt;
      hold_addr_r <= hold_addr_nxt;
      freq_r      <= freq_nxt;
      pofs_r      <= pofs_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and phase offset

  always_comb begin
    fsel_nxt  = fsel_r;
    psel_nxt  = psel_r;
    acc_nxt   = acc_r;
    phase_nxt = phase_r;
    awake_nxt = s_sleep_n;
    if (s_sleep_n) begin
      fsel_nxt  = s_fsel;
      psel_nxt  = {s_pshi, s_pslo};
      acc_nxt   = acc_r + freq_r[fsel_r];
      phase_nxt = nco_phase_type'(
                    acc_r[`NCO_ACC_W-1 -: `NCO_PHASE_W] + pofs_r[psel_r]);
    end
    if (!s_reset_n) begin
      acc_nxt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fsel_r  <= 1'b0;
      psel_r  <= 2'h0;
      acc_r   <= '0;
      phase_r <= '0;
      awake_r <= 1'b0;
    end else begin
      fsel_r  <= fsel_nxt;
      psel_r  <= psel_nxt;
      acc_r   <= acc_nxt;
      phase_r <= phase_nxt;
      awake_r <= awake_nxt;
    end
  end

  assign sine_phase      = phase_r;
  assign dac_enable      = awake_r;
  assign ref_voltage_out = awake_r;

endmodule : nco_dev

// >>> rtl/nco_host.sv
/*
  Host controller end: AXI4-Lite slave with control, command and status
  registers, driving the NCO pins and the write strobe sequence.
  Assumes the device synchronises every pin it reads.
*/
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "nco_regs.svh"

module nco_host
  import nco_pkg::*;
#(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  nco_if.host                link
);

  function automatic logic [31:0] merge(logic [31:0] old_v,
                                        logic [31:0] new_v,
                                        logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        old_v[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge = old_v;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic                   aw_hold_r, aw_hold_nxt;
  logic                   w_hold_r, w_hold_nxt;
  logic [AW-1:0]          awaddr_r, awaddr_nxt;
  logic [31:0]            wdata_r, wdata_nxt;
  logic [3:0]             wstrb_r, wstrb_nxt;
  logic                   bvalid_r, bvalid_nxt;
  logic [1:0]             bresp_r, bresp_nxt;
  logic                   rvalid_r, rvalid_nxt;
  logic [1:0]             rresp_r, rresp_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic [`NCO_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [`NCO_CMD_W-1:0]  cmd_r, cmd_nxt;
  logic                   start;
  logic                   busy;
  logic [31:0]            tmp;

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    ctrl_nxt    = ctrl_r;
    cmd_nxt     = cmd_r;
    start       = 1'b0;
    tmp         = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (aw_hold_r && w_hold_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `NCO_RESP_OKAY;
      case (awaddr_r)
        `NCO_OFS_CTRL: begin
          tmp      = merge(32'(ctrl_r), wdata_r, wstrb_r);
          ctrl_nxt = tmp[`NCO_CTRL_W-1:0];
        end
        `NCO_OFS_CMD: begin
          // A command while a strobe is in flight would corrupt it
          if (busy) begin
            bresp_nxt = `NCO_RESP_SLVERR;
          end else begin
            tmp     = merge(32'(cmd_r), wdata_r, wstrb_r);
            cmd_nxt = tmp[`NCO_CMD_W-1:0];
            start   = 1'b1;
          end
        end
        `NCO_OFS_STATUS: begin
          bresp_nxt = `NCO_RESP_OKAY;
        end
        default: begin
          bresp_nxt = `NCO_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `NCO_RESP_OKAY;
      case (s_axi_araddr)
        `NCO_OFS_CTRL:   rdata_nxt = 32'(ctrl_r);
        `NCO_OFS_CMD:    rdata_nxt = 32'(cmd_r);
        `NCO_OFS_STATUS: rdata_nxt = 32'(busy) << `NCO_STAT_BUSY;
        default: begin
          rdata_nxt = '0;
          rresp_nxt = `NCO_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `NCO_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= `NCO_RESP_OKAY;
      rdata_r   <= '0;
      ctrl_r    <= `NCO_CTRL_RST;
      cmd_r     <= `NCO_CMD_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      cmd_r     <= cmd_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe sequence

  nco_seq_type           st_r, st_nxt;
  logic [`NCO_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                  wr_n_r, wr_n_nxt;
  nco_half_type          data_r, data_nxt;
  nco_dest_type          addr_r, addr_nxt;

  assign busy = (st_r != NCO_IDLE);

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_n_nxt = wr_n_r;
    data_nxt = data_r;
    addr_nxt = addr_r;
    case (st_r)
      NCO_IDLE: begin
        if (start) begin
          data_nxt = cmd_nxt[`NCO_HALF_W-1:0];
          addr_nxt = cmd_nxt[`NCO_CMD_ADDR_LSB +: `NCO_ADDR_W];
          wr_n_nxt = 1'b0;
          cnt_nxt  = `NCO_STROBE_CYC - 4'h1;
          st_nxt   = NCO_STROBE;
        end
      end
      NCO_STROBE: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == '0) begin
          wr_n_nxt = 1'b1;
          cnt_nxt  = `NCO_HOLD_CYC - 4'h1;
          st_nxt   = NCO_HOLD;
        end
      end
      NCO_HOLD: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == '0) begin
          st_nxt = NCO_IDLE;
        end
      end
      default: begin
        st_nxt   = NCO_IDLE;
        wr_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r   <= NCO_IDLE;
      cnt_r  <= '0;
      wr_n_r <= 1'b1;
      data_r <= '0;
      addr_r <= '0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wr_n_r <= wr_n_nxt;
      data_r <= data_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign link.wr_n          = wr_n_r;
  assign link.host_data_bus = data_r;
  assign link.host_addr_bus = addr_r;
  assign link.freq_word_sel = ctrl_r[`NCO_CTRL_FSEL];
  assign link.phase_sel_lo  = ctrl_r[`NCO_CTRL_PSLO];
  assign link.phase_sel_hi  = ctrl_r[`NCO_CTRL_PSHI];
  assign link.sleep_n       = ctrl_r[`NCO_CTRL_SLEEPN];
  assign link.reset_n       = ctrl_r[`NCO_CTRL_RSTN];

endmodule : nco_host

// >>> rtl/nco_if.sv
/*
  Pin-level link between host controller and NCO device.
  Assumes both ends run on the same aclk; the device still synchronises.
*/
`timescale 1ns/1ns

interface nco_if;
  import nco_pkg::*;

  logic         wr_n;
  nco_half_type host_data_bus;
  nco_dest_type host_addr_bus;
  logic         freq_word_sel;
  logic         phase_sel_lo;
  logic         phase_sel_hi;
  logic         sleep_n;
  logic         reset_n;

  modport dev (
    input wr_n,
    input host_data_bus,
    input host_addr_bus,
    input freq_word_sel,
    input phase_sel_lo,
    input phase_sel_hi,
    input sleep_n,
    input reset_n
  );

  modport host (
    output wr_n,
    output host_data_bus,
    output host_addr_bus,
    output freq_word_sel,
    output phase_sel_lo,
    output phase_sel_hi,
    output sleep_n,
    output reset_n
  );
endinterface : nco_if

// >>> rtl/nco_pkg.sv
/*
  Types shared by the NCO link ends.
  Assumes nco_regs.svh is on the include path.
*/
`include "nco_regs.svh"

package nco_pkg;

  typedef logic [`NCO_ACC_W-1:0]   nco_word_type;
  typedef logic [`NCO_PHASE_W-1:0] nco_phase_type;
  typedef logic [`NCO_HALF_W-1:0]  nco_half_type;
  typedef logic [`NCO_ADDR_W-1:0]  nco_dest_type;

  typedef enum logic [1:0] {
    NCO_IDLE   = 2'b00,
    NCO_STROBE = 2'b01,
    NCO_HOLD   = 2'b10
  } nco_seq_type;

endpackage : nco_pkg

// >>> rtl/nco_regs.svh
/*
  Constants for the NCO parallel-load control link and its host registers.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef NCO_REGS_SVH
`define NCO_REGS_SVH

// Datapath widths and register counts
`define NCO_ACC_W       32
`define NCO_HALF_W      16
`define NCO_PHASE_W     12
`define NCO_ADDR_W      3
`define NCO_NUM_POFS    4
`define NCO_NUM_FREQ    2

// Destination address codes on the host address bus
`define NCO_A_FA_LO     3'h0
`define NCO_A_FA_HI     3'h1
`define NCO_A_FB_LO     3'h2
`define NCO_A_FB_HI     3'h3
`define NCO_A_POFS0     3'h4
`define NCO_A_PHASE_BIT 2
`define NCO_A_WORD_BIT  1
`define NCO_A_HALF_BIT  0

// Host register byte offsets
`define NCO_OFS_CTRL    8'h00
`define NCO_OFS_CMD     8'h04
`define NCO_OFS_STATUS  8'h08

// Control register fields
`define NCO_CTRL_FSEL   0
`define NCO_CTRL_PSLO   1
`define NCO_CTRL_PSHI   2
`define NCO_CTRL_SLEEPN 3
`define NCO_CTRL_RSTN   4
`define NCO_CTRL_W      5
`define NCO_CTRL_RST    5'h18

// Command register fields: data in 15:0, destination in 18:16
`define NCO_CMD_ADDR_LSB 16
`define NCO_CMD_W        19
`define NCO_CMD_RST      19'h0_0000

// Status register fields
`define NCO_STAT_BUSY   0

// AXI responses
`define NCO_RESP_OKAY   2'h0
`define NCO_RESP_SLVERR 2'h2

// Host strobe timing in clock cycles
`define NCO_STROBE_CYC  4'h4
`define NCO_HOLD_CYC    4'h4
`define NCO_CNT_W       4

`endif

// >>> rtl/nco_sync.sv
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes the bundle changes slowly compared to aclk.
*/
`timescale 1ns/1ns

module nco_sync #(
  parameter int                WIDTH   = 1,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] dout_nxt;

  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      dout   <= dout_nxt;
    end
  end

endmodule : nco_sync

// >>> sim/nco_props.sv
/*
  Checker for the host-to-device pin link of the NCO pair.
  Assumes the testbench instantiates it beside the link interface.
*/
`timescale 1ns/1ns

module nco_props
  import nco_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         wr_n,
  input wire nco_half_type host_data_bus,
  input wire nco_dest_type host_addr_bus,
  input wire logic         sleep_n,
  input wire logic         reset_n,
  input wire logic         dac_enable,
  input wire logic         ref_voltage_out
);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////
  // strobe low span
  AST_STROBE_LEN: assert property (
    $fell(wr_n) |-> (!wr_n) [*4] ##1 wr_n)
    else $error("write strobe low span wrong");

  AST_DATA_HOLD: assert property (
    $fell(wr_n) |=>
      ($stable(host_data_bus) && $stable(host_addr_bus)) [*7])
    else $error("data or address moved during a write");

  // address kept after rise, device capture lags
  AST_ADDR_HOLD: assert property (
    $rose(wr_n) |-> $stable(host_addr_bus) [*4])
    else $error("address moved before capture");

  AST_STROBE_GAP: assert property (
    $rose(wr_n) |-> wr_n [*5])
    else $error("write strobes too close");

  AST_RESET_PINS: assert property (
    $rose(aresetn) |-> wr_n && sleep_n && reset_n)
    else $error("link pins not idle after reset");

  AST_SLEEP_OFF: assert property (
    (!sleep_n) [*5] |-> !dac_enable && !ref_voltage_out)
    else $error("converter on while asleep");

  AST_WAKE_ON: assert property (
    sleep_n [*5] |-> dac_enable && ref_voltage_out)
    else $error("converter off while awake");

  AST_REF_TRACK: assert property (
    $changed(sleep_n) |-> ##3 (ref_voltage_out == sleep_n))
    else $error("reference enable lags sleep pin");

endmodule : nco_props

// >>> sim/tb.sv
/*
  Testbench: host controller and NCO device joined over the pin link.
  Assumes software access only through the AXI4-Lite port of the host.
*/
`timescale 1ns/1ns
`include "nco_regs.svh"

module tb
  import nco_pkg::*;
;
  logic          aclk;
  logic          aresetn;
  logic [7:0]    awaddr;
  logic          awvalid;
  logic          awready;
  logic [31:0]   wdata;
  logic          wvalid;
  logic          wready;
  logic [1:0]    bresp;
  logic          bvalid;
  logic          bready;
  logic [7:0]    araddr;
  logic          arvalid;
  logic          arready;
  logic [31:0]   rdata;
  logic [1:0]    rresp;
  logic          rvalid;
  logic          rready;
  nco_phase_type sine_phase;
  logic          dac_enable;
  logic          ref_voltage_out;
  int            err_count;
  int            compares;
  logic [11:0]   ofs [4] = '{12'h123, 12'h456, 12'h789, 12'hABC};

  nco_if link_if ();

  nco_host #(.AW(8)) nco_host_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if)
  );

  nco_dev nco_dev_i (
    .aclk(aclk), .aresetn(aresetn), .link(link_if),
    .sine_phase(sine_phase), .dac_enable(dac_enable),
    .ref_voltage_out(ref_voltage_out)
  );

  nco_props nco_props_i (
    .aclk(aclk), .aresetn(aresetn), .wr_n(link_if.wr_n),
    .host_data_bus(link_if.host_data_bus),
    .host_addr_bus(link_if.host_addr_bus), .sleep_n(link_if.sleep_n),
    .reset_n(link_if.reset_n), .dac_enable(dac_enable),
    .ref_voltage_out(ref_voltage_out)
  );

  always #4 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("Compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Ready is looked at on the falling edge so the sample is settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic da;
    logic dw;
    logic ta;
    logic tw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = !da && awready;
      tw = !dw && wready;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        da = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axi_rd

  // Control bits in order reset_n, sleep_n, sel_hi, sel_lo, freq_sel
  task automatic ctrl(input logic [4:0] v);
    logic [1:0] r;
    axi_wr(`NCO_OFS_CTRL, {27'h0, v}, r);
    repeat (8) @(posedge aclk);
  endtask : ctrl

  task automatic wait_idle;
    logic [31:0] s;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      axi_rd(`NCO_OFS_STATUS, s, r);
      n++;
    end while (s[`NCO_STAT_BUSY] !== 1'b0 && n < 50);
    // A strobe sequence that never ends counts as a mismatch
    chk("strobe done", 32'h0, {31'h0, s[`NCO_STAT_BUSY]});
    repeat (4) @(posedge aclk);
  endtask : wait_idle

  task automatic cmd(input logic [2:0] a, input logic [15:0] d);
    logic [1:0] r;
    axi_wr(`NCO_OFS_CMD, {13'h0, a, d}, r);
    wait_idle();
  endtask : cmd

  task automatic getd(output logic [11:0] d);
    logic [11:0] p;
    @(negedge aclk);
    p = sine_phase;
    @(negedge aclk);
    d = sine_phase - p;
  endtask : getd

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(`NCO_OFS_CTRL, d, r);
    chk("ctrl reset", 32'h0000_0018, d);
    axi_rd(8'h0C, d, r);
    chk("unmapped read resp", `NCO_RESP_SLVERR, r);
    chk("unmapped read data", 32'h0000_0000, d);
    axi_wr(8'h0C, 32'h0000_0001, r);
    chk("unmapped write resp", `NCO_RESP_SLVERR, r);
    $display("Test regs done");
  endtask : t_regs

  task automatic t_phase;
    logic [1:0] r;
    ctrl(5'b01000);
    axi_wr(`NCO_OFS_CMD, {13'h0, `NCO_A_POFS0, 4'hF, ofs[0]}, r);
    // Second command while busy must leave offset 0 untouched
    axi_wr(`NCO_OFS_CMD, {13'h0, `NCO_A_POFS0, 16'h0FFF}, r);
    chk("busy cmd resp", `NCO_RESP_SLVERR, r);
    wait_idle();
    for (int i = 1; i < 4; i++) cmd(`NCO_A_POFS0 + 3'(i), {4'hF, ofs[i]});
    for (int i = 0; i < 4; i++) begin
      ctrl({2'b01, 2'(i), 1'b0});
      chk("phase offset", {20'h0, ofs[i]}, {20'h0, sine_phase});
      chk("phase index", {20'h0, ofs[i]}, {20'h0, sine_phase});
    end
    $display("Test phase done");
  endtask : t_phase

  task automatic t_freq;
    logic [11:0] d;
    ctrl(5'b01000);
    cmd(`NCO_A_FA_LO, 16'h0000);
    cmd(`NCO_A_FA_HI, 16'h0010);
    cmd(`NCO_A_FB_LO, 16'h0000);
    cmd(`NCO_A_FB_HI, 16'hFFF0);
    ctrl(5'b11000);
    getd(d);
    chk("step word a", 32'h0000_0001, {20'h0, d});
    ctrl(5'b11001);
    getd(d);
    chk("step word b wraps", 32'h0000_0FFF, {20'h0, d});
    $display("Test freq done");
  endtask : t_freq

  task automatic t_sleep;
    logic [11:0] d;
    ctrl(5'b10001);
    chk("dac asleep", 32'h0, {31'h0, dac_enable});
    chk("ref asleep", 32'h0, {31'h0, ref_voltage_out});
    getd(d);
    chk("frozen step", 32'h0, {20'h0, d});
    ctrl(5'b11001);
    chk("dac awake", 32'h1, {31'h0, dac_enable});
    chk("ref awake", 32'h1, {31'h0, ref_voltage_out});
    getd(d);
    chk("resumed step", 32'h0000_0FFF, {20'h0, d});
    ctrl(5'b01001);
    chk("cleared acc", {20'h0, ofs[0]}, {20'h0, sine_phase});
    $display("Test sleep done");
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk      = 1'b0;
    aresetn   = 1'b0;
    awaddr    = 8'h00;
    awvalid   = 1'b0;
    wdata     = 32'h0000_0000;
    wvalid    = 1'b0;
    bready    = 1'b0;
    araddr    = 8'h00;
    arvalid   = 1'b0;
    rready    = 1'b0;
    err_count = 0;
    compares  = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_phase();
    t_freq();
    t_sleep();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    stop_test();
  end

endmodule : tb
